// File: hw/rblc_pkg.sv
// package for the repeat block loop control
package rblc_pkg;
	localparam int unsigned rblc_cnt_w = 16;
	localparam int unsigned rblc_len_w = 7;
	localparam int unsigned rblc_pc_w = 22;
	localparam int unsigned rblc_shadow_bit = 31;
	localparam int unsigned rblc_active_bit = 30;
	localparam int unsigned rblc_len_lsb = 23;
	localparam int unsigned rblc_end_lsb = 16;
	localparam int unsigned rblc_cnt_lsb = 0;
	localparam logic [11:0] rblc_loop_state_off = 12'h000;
	localparam logic [11:0] rblc_loop_start_off = 12'h004;
	localparam logic [31:0] rblc_loop_state_rst = 32'h0000_0000;
	localparam logic [1:0] rblc_resp_okay = 2'h0;
	localparam logic [1:0] rblc_resp_slverr = 2'h2;
	localparam logic [1:0] rblc_resp_decerr = 2'h3;
endpackage : rblc_pkg

// File: hw/rblc_top.sv
// repeat block loop control with read-only axi4-lite view
// Contract
// [RULE1] nonzero count at repeat sets active flag
// [RULE2] zero count runs block once, flag clear
// [RULE3] load 16-bit count, decrement at block end
// [RULE4] count hits zero: clear flag, final pass
// [RULE5] interrupt: flag to shadow, clear flag
// [RULE6] interrupt return: shadow to flag, clear shadow
// [RULE7] load 7-bit block length from opcode
// [RULE8] program uses legal block lengths only
// [RULE9] end address is low pc plus one plus length
// [RULE10] state register read-only, ignores debugger writes
// [RULE11] active and end match: redirect fetch to start
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rblc_top #(
	parameter int unsigned pc_w = rblc_pkg::rblc_pc_w
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rpt_exec,
	input wire logic [pc_w-1:0] rpt_pc,
	input wire logic [rblc_pkg::rblc_len_w-1:0] rpt_len,
	input wire logic [rblc_pkg::rblc_cnt_w-1:0] rpt_count,
	input wire logic irq_take,
	input wire logic irq_return,
	input wire logic dbg_wr,
	input wire logic [31:0] dbg_wdata,
	input wire logic fetch_valid,
	input wire logic [pc_w-1:0] fetch_pc,
	output logic redirect,
	output logic [pc_w-1:0] redirect_pc,
	output logic loop_active_flag,
	output logic [31:0] loop_state,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// loop state
	logic shadow_r, shadow_nxt;
	logic active_r, active_nxt;
	logic [rblc_pkg::rblc_len_w-1:0] len_r, len_nxt;
	logic [rblc_pkg::rblc_len_w-1:0] end_r, end_nxt;
	logic [rblc_pkg::rblc_cnt_w-1:0] cnt_r, cnt_nxt;
	logic [pc_w-1:0] start_r, start_nxt;
	logic redir_r, redir_nxt;
	logic [pc_w-1:0] redir_pc_r, redir_pc_nxt;
	logic at_end;

	function automatic logic [31:0] pack_state(input logic sh, input logic ac,
		input logic [6:0] ln, input logic [6:0] en, input logic [15:0] ct);
		logic [31:0] v;
		v = rblc_pkg::rblc_loop_state_rst;
		v[rblc_pkg::rblc_shadow_bit] = sh;
		v[rblc_pkg::rblc_active_bit] = ac;
		v[rblc_pkg::rblc_len_lsb +: 7] = ln;
		v[rblc_pkg::rblc_end_lsb +: 7] = en;
		v[rblc_pkg::rblc_cnt_lsb +: 16] = ct;
		return v;
	endfunction : pack_state

	// debugger writes land nowhere; the state only follows instruction flow
	logic unused_dbg;
	assign unused_dbg = dbg_wr ^ (^dbg_wdata); // RULE10

	// only the low 7 pc bits are compared, so blocks stay below 128 words
	assign at_end = fetch_valid && active_r && (fetch_pc[6:0] == end_r); // RULE8

	always_comb begin
		shadow_nxt = shadow_r;
		active_nxt = active_r;
		len_nxt = len_r;
		end_nxt = end_r;
		cnt_nxt = cnt_r;
		start_nxt = start_r;
		if (irq_take) begin
			shadow_nxt = active_r; // RULE5
			active_nxt = 1'b0; // RULE5
		end else if (irq_return) begin
			active_nxt = shadow_r; // RULE6
			shadow_nxt = 1'b0; // RULE6
		end else if (rpt_exec) begin
			len_nxt = rpt_len; // RULE7
			end_nxt = 7'(rpt_pc[6:0] + 7'h01 + rpt_len); // RULE9
			cnt_nxt = rpt_count; // RULE3
			active_nxt = (rpt_count != 16'h0000); // RULE1 RULE2
			start_nxt = pc_w'(rpt_pc + pc_w'(1));
		end else if (at_end) begin
			if (cnt_r == 16'h0001 || cnt_r == 16'h0000) begin
				active_nxt = 1'b0; // RULE4
			end
			// the redirect still fires so the block runs one final time
			cnt_nxt = cnt_r - 16'h0001; // RULE3 RULE4
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			shadow_r <= 1'b0;
			active_r <= 1'b0;
			len_r <= '0;
			end_r <= '0;
			cnt_r <= '0;
			start_r <= '0;
		end else begin
			shadow_r <= shadow_nxt;
			active_r <= active_nxt;
			len_r <= len_nxt;
			end_r <= end_nxt;
			cnt_r <= cnt_nxt;
			start_r <= start_nxt;
		end
	end

	// interrupt, return and repeat take priority over the redirect, so a taken interrupt swallows an end match
	logic end_hit;
	assign end_hit = at_end && !irq_take && !irq_return && !rpt_exec;

	always_comb begin
		redir_nxt = 1'b0;
		redir_pc_nxt = redir_pc_r;
		if (end_hit) begin
			redir_nxt = 1'b1; // RULE11
			redir_pc_nxt = start_r; // RULE11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			redir_r <= 1'b0;
			redir_pc_r <= '0;
		end else begin
			redir_r <= redir_nxt;
			redir_pc_r <= redir_pc_nxt;
		end
	end

	// axi4-lite slave: writes answered slverr or decerr, nothing stored
	logic awrdy_r, awrdy_nxt, aw_r, aw_nxt;
	logic wrdy_r, wrdy_nxt, w_r, w_nxt;
	logic bv_r, bv_nxt;
	logic [11:0] awa_r, awa_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arr_r, arr_nxt, rv_r, rv_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] state_r, state_nxt;
	logic unused_axi;

	// write data and byte lanes have nowhere to land in read-only words
	assign unused_axi = (^s_axi_wdata) ^ (^s_axi_wstrb); // RULE10

	// one decode for both channels keeps the write and read maps in step
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		logic [1:0] s;
		s = 2'h0;
		if (a[11:2] == rblc_pkg::rblc_loop_state_off[11:2]) begin
			s = 2'h1;
		end else if (a[11:2] == rblc_pkg::rblc_loop_start_off[11:2]) begin
			s = 2'h2;
		end
		return s;
	endfunction : reg_sel

	// ready is a one-cycle registered pulse; a new request waits for bresp to drain
	always_comb begin
		awrdy_nxt = 1'b0;
		aw_nxt = aw_r;
		awa_nxt = awa_r;
		wrdy_nxt = 1'b0;
		w_nxt = w_r;
		bv_nxt = bv_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && !awrdy_r && !aw_r && !bv_r) begin
			awrdy_nxt = 1'b1;
		end
		if (s_axi_awvalid && awrdy_r) begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wrdy_r && !w_r && !bv_r) begin
			wrdy_nxt = 1'b1;
		end
		if (s_axi_wvalid && wrdy_r) begin
			w_nxt = 1'b1;
		end
		if (aw_r && w_r && !bv_r) begin
			bv_nxt = 1'b1;
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			if (reg_sel(awa_r) != 2'h0) begin
				bresp_nxt = rblc_pkg::rblc_resp_slverr; // RULE10
			end else begin
				bresp_nxt = rblc_pkg::rblc_resp_decerr;
			end
		end
		if (bv_r && s_axi_bready) begin
			bv_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			awrdy_r <= 1'b0;
			aw_r <= 1'b0;
			awa_r <= '0;
			wrdy_r <= 1'b0;
			w_r <= 1'b0;
			bv_r <= 1'b0;
			bresp_r <= rblc_pkg::rblc_resp_okay;
		end else begin
			awrdy_r <= awrdy_nxt;
			aw_r <= aw_nxt;
			awa_r <= awa_nxt;
			wrdy_r <= wrdy_nxt;
			w_r <= w_nxt;
			bv_r <= bv_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// rvalid only after the address handshake; data taken while araddr still stands
	always_comb begin
		arr_nxt = 1'b0;
		rv_nxt = rv_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && !arr_r && !rv_r) begin
			arr_nxt = 1'b1;
		end
		if (s_axi_arvalid && arr_r) begin
			rv_nxt = 1'b1;
			rresp_nxt = rblc_pkg::rblc_resp_okay;
			unique case (reg_sel(s_axi_araddr))
				2'h1: rdata_nxt = state_r;
				2'h2: rdata_nxt = 32'(start_r);
				default: begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = rblc_pkg::rblc_resp_decerr;
				end
			endcase
		end else if (rv_r && s_axi_rready) begin
			rv_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			arr_r <= 1'b0;
			rv_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= rblc_pkg::rblc_resp_okay;
		end else begin
			arr_r <= arr_nxt;
			rv_r <= rv_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// image built from next values so a read never lags the loop state
	always_comb begin
		state_nxt = pack_state(shadow_nxt, active_nxt, len_nxt, end_nxt, cnt_nxt);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_r <= rblc_pkg::rblc_loop_state_rst;
		end else begin
			state_r <= state_nxt;
		end
	end

	// every output comes straight from a register
	assign redirect = redir_r;
	assign redirect_pc = redir_pc_r;
	assign loop_active_flag = active_r;
	assign loop_state = state_r;
	assign s_axi_awready = awrdy_r;
	assign s_axi_wready = wrdy_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule : rblc_top
`default_nettype wire

// File: test/rblc_cpu_model.sv
// cpu fetch model that follows loop redirects
`timescale 1ns/10ps
`default_nettype none
module rblc_cpu_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic fetch_valid,
	input wire logic redirect,
	input wire logic [21:0] start_pc,
	input wire logic [21:0] redirect_pc,
	output logic [21:0] fetch_pc
);
	// odd start, length 9 or more: always legal
	always_ff @(posedge sys_clk) begin
		if (!rstn) fetch_pc <= 22'h0;
		else if (load) fetch_pc <= start_pc;
		else if (redirect) fetch_pc <= redirect_pc;
		else if (fetch_valid) fetch_pc <= fetch_pc + 22'h1;
	end
endmodule : rblc_cpu_model
`default_nettype wire

// File: test/rblc_top_sva.sv
// port assertions for the repeat block loop control
`timescale 1ns/10ps
`default_nettype none
module rblc_top_sva #(
	parameter int unsigned pc_w = 22
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic rpt_exec,
	input wire logic [pc_w-1:0] rpt_pc,
	input wire logic [6:0] rpt_len,
	input wire logic [15:0] rpt_count,
	input wire logic irq_take,
	input wire logic irq_return,
	input wire logic dbg_wr,
	input wire logic fetch_valid,
	input wire logic redirect,
	input wire logic loop_active_flag,
	input wire logic [31:0] loop_state
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_rpt;
		rpt_exec && !irq_take && !irq_return;
	endsequence
	sequence s_end;
		!redirect ##1 redirect;
	endsequence
	act_set_a: assert property (s_rpt ##0 rpt_count != 16'h0 |=> loop_active_flag) else $error("no flag");
	zero_cnt_a: assert property (s_rpt ##0 rpt_count == 16'h0 |=> !loop_active_flag) else $error("flag");
	cnt_load_a: assert property (s_rpt |=> loop_state[15:0] == $past(rpt_count)) else $error("count");
	len_load_a: assert property (s_rpt |=> loop_state[29:23] == $past(rpt_len)) else $error("length");
	end_calc_a: assert property (s_rpt |=> loop_state[22:16] == $past(rpt_pc[6:0]) + 7'h01 + $past(rpt_len))
		else $error("end");
	irq_save_a: assert property (irq_take |=> loop_state[31] == $past(loop_active_flag) && !loop_active_flag)
		else $error("save");
	irq_ret_a: assert property (irq_return && !irq_take |=> loop_active_flag == $past(loop_state[31]) && !loop_state[31])
		else $error("restore");
	ro_hold_a: assert property (dbg_wr && !rpt_exec && !irq_take && !irq_return && !fetch_valid |=> $stable(loop_state))
		else $error("written");
	end_dec_a: assert property (s_end |-> loop_state[15:0] == $past(loop_state[15:0]) - 16'h1) else $error("dec");
	last_pass_a: assert property (s_end ##0 loop_state[15:0] == 16'h0 |-> !loop_active_flag) else $error("last");
endmodule : rblc_top_sva
bind rblc_top rblc_top_sva #(.pc_w(pc_w)) rblc_top_sva_i (.*);
`default_nettype wire

// File: test/rblc_top_tb.sv
// self-checking bench for the repeat block loop control
`timescale 1ns/10ps
`default_nettype none
module rblc_top_tb;
	logic sys_clk, rstn, rpt_exec, irq_take, irq_return, dbg_wr, fetch_valid, redirect, loop_active_flag, load;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic [6:0] rpt_len;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [15:0] rpt_count;
	logic [21:0] rpt_pc, fetch_pc, redirect_pc, start_pc;
	logic [31:0] dbg_wdata, s_axi_wdata, s_axi_rdata, loop_state;
	logic [33:0] q[$];
	int seed = 63;
	int err_count, num_checks, cyc;
	rblc_top rblc_top_i (.*);
	rblc_cpu_model rblc_cpu_model_i (.*);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [33:0] v);
		logic [33:0] e;
		e = q.size() > 0 ? q.pop_front() : ~v;
		num_checks++;
		if (v !== e) begin
			err_count++;
			$display("mismatch %0t got %h want %h", $time, v, e);
		end
	endtask : chk
	always @(posedge sys_clk) begin
		// debugger port is noise only: it must never move the state
		dbg_wr <= 1'($random(seed));
		dbg_wdata <= $random(seed);
		if (redirect) chk({12'h0, redirect_pc});
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0});
		if (++cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] e);
		q.push_back({r, e});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [1:0] r);
		q.push_back({r, 32'h0});
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= $random(seed);
		s_axi_wstrb <= 4'($random(seed));
		{s_axi_awvalid, s_axi_wvalid} <= 2'b11;
		fork
			begin
				do @(posedge sys_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge sys_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		while (!s_axi_bvalid) @(posedge sys_clk);
	endtask : wr
	task automatic blk(input logic z, input logic irq);
		logic [31:0] s;
		logic [15:0] n;
		logic [6:0] l, e;
		s = $random(seed);
		l = 7'h09 + {2'h0, s[26:22]};
		n = z ? 16'h0 : {13'h0, s[29:27]} + 16'h1;
		e = {s[6:1], 1'b0} + 7'h01 + l;
		@(posedge sys_clk);
		{rpt_exec, load, rpt_len, rpt_count} <= {2'b11, l, n};
		rpt_pc <= {s[21:1], 1'b0};
		start_pc <= {s[21:1], 1'b1};
		@(posedge sys_clk);
		{rpt_exec, load, irq_take} <= {2'b00, irq};
		if (irq) begin
			@(posedge sys_clk);
			irq_take <= 1'b0;
			rd(12'h000, rblc_pkg::rblc_resp_okay, {2'b10, l, e, n});
			irq_return <= 1'b1;
			@(posedge sys_clk);
			irq_return <= 1'b0;
			rd(12'h000, rblc_pkg::rblc_resp_okay, {2'b01, l, e, n});
		end
		repeat (n) q.push_back({12'h0, s[21:1], 1'b1});
		fetch_valid <= 1'b1;
		repeat ((n + 16'h1) * (l + 7'h04)) @(posedge sys_clk);
		fetch_valid <= 1'b0;
		rd(12'h000, rblc_pkg::rblc_resp_okay, {2'b00, l, e, 16'h0});
		rd(12'h004, rblc_pkg::rblc_resp_okay, {10'h0, s[21:1], 1'b1});
	endtask : blk
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		{rstn, rpt_exec, irq_take, irq_return, fetch_valid, load, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_rready, rpt_len, rpt_count, rpt_pc, start_pc, s_axi_araddr, dbg_wr, dbg_wdata} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = '0;
		s_axi_bready = 1'b1;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		wr(12'h000, rblc_pkg::rblc_resp_slverr);
		wr(12'h010, rblc_pkg::rblc_resp_decerr);
		rd(12'h000, rblc_pkg::rblc_resp_okay, 32'h0);
		rd(12'h008, rblc_pkg::rblc_resp_decerr, 32'h0);
		blk(1'b1, 1'b0);
		blk(1'b0, 1'b0);
		blk(1'b0, 1'b1);
		blk(1'b0, 1'b0);
		end_sim();
	end
endmodule : rblc_top_tb
`default_nettype wire
